// ### verilog/tpam_defines.svh
`ifndef TPAM_DEFINES_SVH
`define TPAM_DEFINES_SVH
`define TPAM_OFF_CTRL 12'h000
`define TPAM_OFF_TTL 12'h004
`define TPAM_OFF_PHASE 12'h008
`define TPAM_OFF_DEPTH 12'h00C
`define TPAM_OFF_SHAPE 12'h010
`define TPAM_OFF_AMFREQ 12'h014
`define TPAM_OFF_CARRIER 12'h018
`define TPAM_OFF_CMD 12'h01C
`define TPAM_OFF_STATUS 12'h020
`define TPAM_OFF_ERR 12'h024
`define TPAM_CTRL_SYNC 0
`define TPAM_CTRL_LEGTRIG 1
`define TPAM_CTRL_UNLKERR 2
`define TPAM_CTRL_EXTONLY 3
`define TPAM_CTRL_DEG 4
`define TPAM_CTRL_MINSEL 5
`define TPAM_CTRL_MAXSEL 6
`define TPAM_CMD_TRIG 0
`define TPAM_CMD_REF 1
`define TPAM_CTRL_RST 32'h0000_0001
`define TPAM_PHASE_MAX_MRAD 32'sd6283
`define TPAM_PHASE_MAX_DEG 32'sd360
`define TPAM_DEPTH_MAX 8'h78
`define TPAM_DEPTH_RST 8'h64
`define TPAM_AMFREQ_MIN_MHZ 32'h0000_000A
`define TPAM_AMFREQ_MAX_MHZ 32'h0131_2D00
`define TPAM_AMFREQ_RST_MHZ 32'h0001_86A0
`define TPAM_CAR_MAX_HZ 32'h00E4_E1C0
`define TPAM_CAR_MAX_TR_HZ 32'h0001_86A0
`define TPAM_CAR_RST_HZ 32'h0000_03E8
`define TPAM_ERR_UNLOCK 16'h0244
`define TPAM_PULSE_NS 100
`define TPAM_CLK_NS 8
`endif

// ### verilog/tpam_pkg.sv
package tpam_pkg;
    typedef enum logic [2:0] {
        TPAM_SH_SIN = 3'h0,
        TPAM_SH_SQU = 3'h1,
        TPAM_SH_TRI = 3'h2,
        TPAM_SH_RAMP = 3'h3,
        TPAM_SH_NOIS = 3'h4,
        TPAM_SH_USER = 3'h5
    } tpam_shape_t;
    typedef enum logic [2:0] {
        TPAM_P_IDLE = 3'b001,
        TPAM_P_HIGH = 3'b010,
        TPAM_P_DONE = 3'b100
    } tpam_pst_t;
    typedef struct packed {
        logic [7:0] depth;
        logic [2:0] shape;
        logic ext_only;
        logic int_enable;
        logic [31:0] mod_freq_mhz;
    } tpam_am_t;
endpackage

// ### verilog/tpam_core.sv
// How it works
// - Sync state reads back 0 when disabled, 1 when enabled.
// - Trigger command emits a positive pulse on front trigger, ignoring legacy bit.
// - Trigger command pulses every enabled backplane line low.
// - Legacy trigger output bit is stored and read but steers nothing.
// - Eight backplane source enables, each off after reset.
// - Backplane enable readback is 0 or 1 per line.
// - Phase commands act only when the phase-lock option is fitted.
// - Phase offset limited to +-2pi rad or +-360 deg; min/max pick ends.
// - Periodic shapes take zero phase at rising zero crossing.
// - Arbitrary shapes take zero phase at first stored sample.
// - Phase offset is kept apart from burst start phase.
// - Phase offset always reads back in milliradians.
// - Reference command restarts zero phase, leaves offset alone.
// - Unlock error enable off at reset; on with lock loss posts 580.
// - Unlock error enable reads back 0 or 1.
// - Depth 0 to 120 percent, min/max pick ends, reset 100.
// - External only: depth follows modulation input, 5 V peak is 100.
// - Six modulating shapes, sine at reset; noise carrier refused.
// - Shape reads back as its code.
// - Modulating frequency 10 mHz to 20 kHz, reset 100 Hz.
// - Carrier limited to 15 MHz, 100 kHz for triangle and ramp.
// - Depth reads back in percent.
// - External only disables the internal modulating source.
`timescale 1ns/1ps
`default_nettype none
`include "tpam_defines.svh"
module tpam_core #(
    parameter bit OPT_PHASE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_locked,
    input wire logic carrier_is_tri_ramp,
    input wire logic carrier_is_noise_dc,
    input wire logic arb_selected,
    input wire logic [7:0] ext_mod_depth,
    output logic sync_enable,
    output logic front_trig_out,
    output logic [7:0] ttltrg_out_n,
    output logic [7:0] ttltrg_oe,
    output logic signed [31:0] phase_offset_mrad,
    output logic phase_zero_ref,
    output logic phase_align_rise,
    output logic [31:0] carrier_freq_hz,
    output tpam_pkg::tpam_am_t am_cfg,
    output logic [7:0] modulation_depth_setting_eff,
    output logic err_post,
    output logic [15:0] err_code
);
    localparam int PULSE_CYC = (`TPAM_PULSE_NS + `TPAM_CLK_NS - 1) / `TPAM_CLK_NS;
    localparam int DEG_MRAD_NUM = 6283;

    function automatic logic [31:0] clamp_u(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
        clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [31:0] ctrl_r;
    logic [7:0] ttl_en_r;
    logic signed [31:0] phase_r;
    logic [7:0] depth_r;
    logic [2:0] shape_r;
    logic [31:0] amfreq_r;
    logic [31:0] carrier_r;
    logic [15:0] err_r;
    logic lock_d_r;
    logic [7:0] pcnt_r;
    tpam_pkg::tpam_pst_t pst_r;
    logic [31:0] rd_nxt;

    wire wr = psel && penable && pwrite;
    wire bad_addr = (paddr[1:0] != 2'b00) || (paddr > `TPAM_OFF_ERR);
    wire cmd_wr = wr && !bad_addr && (paddr == `TPAM_OFF_CMD);
    wire trig_cmd = cmd_wr && pwdata[`TPAM_CMD_TRIG];
    wire ref_cmd = cmd_wr && pwdata[`TPAM_CMD_REF] && OPT_PHASE;
    wire minsel = ctrl_r[`TPAM_CTRL_MINSEL];
    wire maxsel = ctrl_r[`TPAM_CTRL_MAXSEL];
    wire val_wr = wr && !bad_addr && (paddr == `TPAM_OFF_PHASE || paddr == `TPAM_OFF_DEPTH ||
                                      paddr == `TPAM_OFF_AMFREQ);

    assign pready = 1'b1;
    assign pslverr = psel && penable && bad_addr;

    // Control bits; legacy trigger bit is held only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `TPAM_CTRL_RST;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_CTRL) begin
            ctrl_r <= {25'h0, pwdata[6:0]};
        end else if (val_wr) begin
            ctrl_r[`TPAM_CTRL_MAXSEL:`TPAM_CTRL_MINSEL] <= 2'b00;
        end
    end

    // Backplane source enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ttl_en_r <= 8'h00;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_TTL) begin
            ttl_en_r <= pwdata[7:0];
        end
    end

    // Phase offset, degrees converted to mrad, kept apart from burst phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 32'sd0;
        end else if (OPT_PHASE && wr && !bad_addr && paddr == `TPAM_OFF_PHASE) begin
            if (minsel) begin
                phase_r <= -`TPAM_PHASE_MAX_MRAD;
            end else if (maxsel) begin
                phase_r <= `TPAM_PHASE_MAX_MRAD;
            end else if (ctrl_r[`TPAM_CTRL_DEG]) begin
                if ($signed(pwdata) > `TPAM_PHASE_MAX_DEG ||
                    $signed(pwdata) < -`TPAM_PHASE_MAX_DEG) begin
                    phase_r <= phase_r;
                end else begin
                    phase_r <= 32'(($signed(pwdata) * DEG_MRAD_NUM) / 360);
                end
            end else if ($signed(pwdata) <= `TPAM_PHASE_MAX_MRAD &&
                         $signed(pwdata) >= -`TPAM_PHASE_MAX_MRAD) begin
                phase_r <= $signed(pwdata);
            end
        end
    end

    // Depth with range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_r <= `TPAM_DEPTH_RST;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_DEPTH) begin
            if (minsel) begin
                depth_r <= 8'h00;
            end else if (maxsel) begin
                depth_r <= `TPAM_DEPTH_MAX;
            end else if (pwdata <= 32'(`TPAM_DEPTH_MAX)) begin
                depth_r <= pwdata[7:0];
            end
        end
    end

    // Modulating shape, invalid codes refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shape_r <= tpam_pkg::TPAM_SH_SIN;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_SHAPE && pwdata[2:0] <= 3'h5) begin
            shape_r <= pwdata[2:0];
        end
    end

    // Modulating frequency clamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amfreq_r <= `TPAM_AMFREQ_RST_MHZ;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_AMFREQ) begin
            if (minsel) begin
                amfreq_r <= `TPAM_AMFREQ_MIN_MHZ;
            end else if (maxsel) begin
                amfreq_r <= `TPAM_AMFREQ_MAX_MHZ;
            end else begin
                amfreq_r <= clamp_u(pwdata, `TPAM_AMFREQ_MIN_MHZ, `TPAM_AMFREQ_MAX_MHZ);
            end
        end
    end

    // Carrier limit by shape
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_r <= `TPAM_CAR_RST_HZ;
        end else if (wr && !bad_addr && paddr == `TPAM_OFF_CARRIER) begin
            carrier_r <= clamp_u(pwdata, 32'h1, carrier_is_tri_ramp ?
                                 `TPAM_CAR_MAX_TR_HZ : `TPAM_CAR_MAX_HZ);
        end else if (carrier_is_tri_ramp && carrier_r > `TPAM_CAR_MAX_TR_HZ) begin
            carrier_r <= `TPAM_CAR_MAX_TR_HZ;
        end
    end

    // Trigger pulse sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_r <= tpam_pkg::TPAM_P_IDLE;
            pcnt_r <= 8'h00;
        end else begin
            case (pst_r)
                tpam_pkg::TPAM_P_IDLE: begin
                    if (trig_cmd) begin
                        pst_r <= tpam_pkg::TPAM_P_HIGH;
                        pcnt_r <= 8'(PULSE_CYC - 1);
                    end
                end
                tpam_pkg::TPAM_P_HIGH: begin
                    if (pcnt_r == 8'h00) begin
                        pst_r <= tpam_pkg::TPAM_P_DONE;
                    end else begin
                        pcnt_r <= pcnt_r - 8'h01;
                    end
                end
                tpam_pkg::TPAM_P_DONE: begin
                    pst_r <= tpam_pkg::TPAM_P_IDLE;
                end
                default: begin
                    pst_r <= tpam_pkg::TPAM_P_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            front_trig_out <= 1'b0;
            ttltrg_out_n <= 8'hFF;
            ttltrg_oe <= 8'h00;
        end else begin
            front_trig_out <= (pst_r == tpam_pkg::TPAM_P_HIGH);
            ttltrg_out_n <= (pst_r == tpam_pkg::TPAM_P_HIGH) ? ~ttl_en_r : 8'hFF;
            ttltrg_oe <= ttl_en_r;
        end
    end

    // Zero-phase reference pulse; offset untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_zero_ref <= 1'b0;
            phase_align_rise <= 1'b1;
        end else begin
            phase_zero_ref <= ref_cmd;
            phase_align_rise <= !arb_selected;
        end
    end

    // Unlock error posting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_d_r <= 1'b1;
            err_r <= 16'h0000;
            err_post <= 1'b0;
        end else begin
            lock_d_r <= pll_locked;
            err_post <= 1'b0;
            if (OPT_PHASE && ctrl_r[`TPAM_CTRL_UNLKERR] && lock_d_r && !pll_locked) begin
                err_r <= `TPAM_ERR_UNLOCK;
                err_post <= 1'b1;
            end else if (wr && !bad_addr && paddr == `TPAM_OFF_ERR) begin
                err_r <= 16'h0000;
            end
        end
    end

    // Datapath outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_enable <= 1'b1;
            phase_offset_mrad <= 32'sd0;
            carrier_freq_hz <= `TPAM_CAR_RST_HZ;
            am_cfg.depth <= `TPAM_DEPTH_RST;
            am_cfg.shape <= 3'h0;
            am_cfg.ext_only <= 1'b0;
            am_cfg.int_enable <= 1'b1;
            am_cfg.mod_freq_mhz <= `TPAM_AMFREQ_RST_MHZ;
            modulation_depth_setting_eff <= `TPAM_DEPTH_RST;
        end else begin
            sync_enable <= ctrl_r[`TPAM_CTRL_SYNC];
            phase_offset_mrad <= phase_r;
            carrier_freq_hz <= carrier_r;
            am_cfg.depth <= depth_r;
            am_cfg.shape <= shape_r;
            am_cfg.ext_only <= ctrl_r[`TPAM_CTRL_EXTONLY];
            am_cfg.int_enable <= !ctrl_r[`TPAM_CTRL_EXTONLY] && !carrier_is_noise_dc;
            am_cfg.mod_freq_mhz <= amfreq_r;
            modulation_depth_setting_eff <= ctrl_r[`TPAM_CTRL_EXTONLY] ? ext_mod_depth : depth_r;
        end
    end
    assign err_code = err_r;

    // Read decode
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            `TPAM_OFF_CTRL: rd_nxt = ctrl_r;
            `TPAM_OFF_TTL: rd_nxt = {24'h0, ttl_en_r};
            `TPAM_OFF_PHASE: rd_nxt = phase_r;
            `TPAM_OFF_DEPTH: rd_nxt = {24'h0, depth_r};
            `TPAM_OFF_SHAPE: rd_nxt = {29'h0, shape_r};
            `TPAM_OFF_AMFREQ: rd_nxt = amfreq_r;
            `TPAM_OFF_CARRIER: rd_nxt = carrier_r;
            `TPAM_OFF_STATUS: rd_nxt = {29'h0, OPT_PHASE, pll_locked,
                                        pst_r != tpam_pkg::TPAM_P_IDLE};
            `TPAM_OFF_ERR: rd_nxt = {16'h0, err_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data loaded in the setup phase, stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    depth_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        depth_r <= `TPAM_DEPTH_MAX) else $error("depth over range");
    trig_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig_cmd && pst_r == tpam_pkg::TPAM_P_IDLE |=> ##1 front_trig_out)
        else $error("trigger pulse missing");
    ttl_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ttltrg_out_n | $past(ttl_en_r)) == 8'hFF) else $error("disabled line pulsed");
    phase_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase_r <= `TPAM_PHASE_MAX_MRAD && phase_r >= -`TPAM_PHASE_MAX_MRAD)
        else $error("phase out of range");
    ref_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
        ref_cmd |=> $stable(phase_r)) else $error("reference changed offset");
    unlock_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        OPT_PHASE && ctrl_r[`TPAM_CTRL_UNLKERR] && lock_d_r && !pll_locked
        |=> err_post && err_code == `TPAM_ERR_UNLOCK) else $error("no unlock error");
    freq_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        amfreq_r >= `TPAM_AMFREQ_MIN_MHZ && amfreq_r <= `TPAM_AMFREQ_MAX_MHZ)
        else $error("mod freq out of range");
    ext_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[`TPAM_CTRL_EXTONLY] |=> !am_cfg.int_enable && modulation_depth_setting_eff == $past(ext_mod_depth))
        else $error("internal source active");
    sync_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        sync_enable == $past(ctrl_r[`TPAM_CTRL_SYNC])) else $error("sync state mismatch");
    oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ttltrg_oe == $past(ttl_en_r)) else $error("line enable mismatch");
    ttl_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        ttltrg_out_n == (front_trig_out ? ~ttltrg_oe : 8'hFF))
        else $error("backplane pulse mismatch");
    front_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(front_trig_out) |-> front_trig_out [*8] ##1 front_trig_out [*5]
        ##1 !front_trig_out) else $error("trigger pulse width");
    shape_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        shape_r <= 3'h5) else $error("shape code invalid");
    carrier_tri_a: assert property (@(posedge pclk) disable iff (!presetn)
        carrier_is_tri_ramp |=> carrier_r <= `TPAM_CAR_MAX_TR_HZ)
        else $error("carrier over limit");
    ref_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        ref_cmd |=> phase_zero_ref) else $error("reference pulse missing");
    keyword_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        val_wr |=> !minsel && !maxsel) else $error("keyword left armed");
endmodule
`default_nettype wire

// ### bench/tpam_host.sv
`timescale 1ns/1ps
`default_nettype none
module tpam_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One APB transfer, setup on the next edge, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### bench/trigger_phase_am_command_set_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpam_defines.svh"
module trigger_phase_am_command_set_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, carrier_freq_hz, q;
    logic pll_locked, tri_r, noise_dc, arb_sel, front_trig_out, zref, align, err_post, e;
    logic [7:0] ext_depth, ttl_n, ttl_oe, am_eff, low;
    logic signed [31:0] phase_mrad;
    logic [15:0] err_code;
    tpam_pkg::tpam_am_t am_cfg;
    int err_total, checks_done, cyc, nt, nr, ne;
    tpam_core #(.OPT_PHASE(1'h1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked),
        .carrier_is_tri_ramp(tri_r), .carrier_is_noise_dc(noise_dc), .arb_selected(arb_sel),
        .ext_mod_depth(ext_depth), .sync_enable(sync_enable), .front_trig_out(front_trig_out),
        .ttltrg_out_n(ttl_n), .ttltrg_oe(ttl_oe), .phase_offset_mrad(phase_mrad),
        .phase_zero_ref(zref), .phase_align_rise(align), .carrier_freq_hz(carrier_freq_hz),
        .am_cfg(am_cfg), .modulation_depth_setting_eff(am_eff), .err_post(err_post), .err_code(err_code));
    tpam_host HOST (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        HOST.xfer(1'h1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        HOST.xfer(1'h0, a, 32'h0000_0000, q, e);
        chk(q, x, "read");
    endtask
    task automatic settle();
        repeat (3) @(negedge pclk);
    endtask
    // Counts the cycles each event output is high over the following 30 cycles
    task automatic pulses();
        nt = 0; nr = 0; ne = 0; low = 8'hFF;
        repeat (30) begin
            @(negedge pclk);
            nt += int'(front_trig_out === 1'h1);
            nr += int'(zref === 1'h1);
            ne += int'(err_post === 1'h1);
            if (front_trig_out === 1'h1) low = ttl_n;
        end
    endtask
    task automatic rstchk();
        rd(`TPAM_OFF_CTRL, `TPAM_CTRL_RST);
        rd(`TPAM_OFF_TTL, 32'h0000_0000);
        rd(`TPAM_OFF_PHASE, 32'h0000_0000);
        rd(`TPAM_OFF_DEPTH, 32'h0000_0064);
        rd(`TPAM_OFF_SHAPE, 32'h0000_0000);
        rd(`TPAM_OFF_AMFREQ, 32'h0001_86A0);
        rd(`TPAM_OFF_STATUS, 32'h0000_0006);
        chk(carrier_freq_hz, 32'h0000_03E8, "carrier");
        chk({16'h0000, err_code}, 32'h0000_0000, "err");
        $display("test reset done");
    endtask
    initial begin
        presetn = 1'h0; pll_locked = 1'h1; tri_r = 1'h0; noise_dc = 1'h0; arb_sel = 1'h0;
        ext_depth = 8'h00; err_total = 0; checks_done = 0; cyc = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rstchk();
        wr(`TPAM_OFF_CTRL, 32'h0000_0002);
        rd(`TPAM_OFF_CTRL, 32'h0000_0002);
        settle();
        chk({31'h0, sync_enable}, 32'h0000_0000, "sync");
        wr(`TPAM_OFF_TTL, 32'h0000_00A5);
        rd(`TPAM_OFF_TTL, 32'h0000_00A5);
        settle();
        chk({24'h0, ttl_oe}, 32'h0000_00A5, "oe");
        for (int l = 0; l < 2; l++) begin
            wr(`TPAM_OFF_CTRL, l ? 32'h0000_0003 : 32'h0000_0001);
            wr(`TPAM_OFF_CMD, 32'h0000_0001);
            pulses();
            chk(nt, 13, "trig width");
            chk({24'h0, low}, 32'h0000_005A, "ttl low");
        end
        $display("test trigger done");
        wr(`TPAM_OFF_PHASE, 32'h0000_188B);
        wr(`TPAM_OFF_PHASE, 32'h0000_188C);
        rd(`TPAM_OFF_PHASE, 32'h0000_188B);
        wr(`TPAM_OFF_CTRL, 32'h0000_0011);
        wr(`TPAM_OFF_PHASE, 32'hFFFF_FE98);
        rd(`TPAM_OFF_PHASE, 32'hFFFF_E775);
        wr(`TPAM_OFF_CMD, 32'h0000_0002);
        pulses();
        chk(nr, 1, "zero ref");
        rd(`TPAM_OFF_PHASE, 32'hFFFF_E775);
        chk(phase_mrad, 32'hFFFF_E775, "phase out");
        wr(`TPAM_OFF_CTRL, 32'h0000_0041);
        wr(`TPAM_OFF_PHASE, 32'h0000_0000);
        rd(`TPAM_OFF_PHASE, 32'h0000_188B);
        wr(`TPAM_OFF_CTRL, 32'h0000_0021);
        wr(`TPAM_OFF_PHASE, 32'h0000_0000);
        rd(`TPAM_OFF_PHASE, 32'hFFFF_E775);
        @(posedge pclk) arb_sel <= 1'h1;
        settle();
        chk({31'h0, align}, 32'h0000_0000, "arb align");
        @(posedge pclk) arb_sel <= 1'h0;
        settle();
        chk({31'h0, align}, 32'h0000_0001, "rise align");
        @(posedge pclk) pll_locked <= 1'h0;
        pulses();
        chk(ne, 0, "no err");
        @(posedge pclk) pll_locked <= 1'h1;
        wr(`TPAM_OFF_CTRL, 32'h0000_0005);
        rd(`TPAM_OFF_CTRL, 32'h0000_0005);
        @(posedge pclk) pll_locked <= 1'h0;
        pulses();
        chk(ne, 1, "err post");
        chk({16'h0000, err_code}, 32'h0000_0244, "err code");
        @(posedge pclk) pll_locked <= 1'h1;
        $display("test phase done");
        wr(`TPAM_OFF_DEPTH, 32'h0000_0018);
        wr(`TPAM_OFF_DEPTH, 32'h0000_0080);
        rd(`TPAM_OFF_DEPTH, 32'h0000_0018);
        chk({24'h0, am_cfg.depth}, 32'h0000_0018, "depth");
        wr(`TPAM_OFF_DEPTH, 32'h0000_0064);
        rd(`TPAM_OFF_DEPTH, 32'h0000_0064);
        wr(`TPAM_OFF_CTRL, 32'h0000_0045);
        wr(`TPAM_OFF_DEPTH, 32'h0000_0010);
        rd(`TPAM_OFF_DEPTH, 32'h0000_0078);
        rd(`TPAM_OFF_CTRL, 32'h0000_0005);
        wr(`TPAM_OFF_CTRL, 32'h0000_0025);
        wr(`TPAM_OFF_DEPTH, 32'h0000_0010);
        rd(`TPAM_OFF_DEPTH, 32'h0000_0000);
        ext_depth <= 8'h3C;
        wr(`TPAM_OFF_CTRL, 32'h0000_0009);
        settle();
        chk({24'h0, am_eff}, 32'h0000_003C, "ext depth");
        chk({31'h0, am_cfg.int_enable}, 32'h0000_0000, "int off");
        chk({31'h0, am_cfg.ext_only}, 32'h0000_0001, "ext only");
        for (int s = 0; s < 7; s++) begin
            wr(`TPAM_OFF_SHAPE, 32'(s));
            rd(`TPAM_OFF_SHAPE, s < 6 ? 32'(s) : 32'h0000_0005);
        end
        chk({29'h0, am_cfg.shape}, 32'h0000_0005, "shape out");
        wr(`TPAM_OFF_AMFREQ, 32'h0000_0005);
        rd(`TPAM_OFF_AMFREQ, 32'h0000_000A);
        wr(`TPAM_OFF_AMFREQ, 32'h0140_0000);
        rd(`TPAM_OFF_AMFREQ, 32'h0131_2D00);
        wr(`TPAM_OFF_CTRL, 32'h0000_0029);
        wr(`TPAM_OFF_AMFREQ, 32'h0000_1000);
        rd(`TPAM_OFF_AMFREQ, 32'h0000_000A);
        chk(am_cfg.mod_freq_mhz, 32'h0000_000A, "mod freq");
        wr(`TPAM_OFF_CARRIER, 32'h00F0_0000);
        settle();
        chk(carrier_freq_hz, 32'h00E4_E1C0, "carrier max");
        tri_r <= 1'h1;
        wr(`TPAM_OFF_CARRIER, 32'h00F0_0000);
        settle();
        chk(carrier_freq_hz, 32'h0001_86A0, "carrier tri");
        HOST.xfer(1'h0, 12'h028, 32'h0000_0000, q, e);
        chk({31'h0, e}, 32'h0000_0001, "unmapped");
        $display("test am done");
        @(posedge pclk) presetn <= 1'h0;
        tri_r <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rstchk();
        final_report();
    end
endmodule
`default_nettype wire
